// ### logic/asq_defs.svh
// Constants for the converter scan and select sequencer
`ifndef ASQ_DEFS_SVH
`define ASQ_DEFS_SVH

// Bus and data widths
`define ASQ_AW 4
`define ASQ_DW 16
`define ASQ_RW 10
`define ASQ_NCH 8
`define ASQ_CW 11

// Register addresses (word index on the plain port)
`define ASQ_A_IRQ 4'h0
`define ASQ_A_SCAN 4'h1
`define ASQ_A_SEL 4'h2
`define ASQ_A_REQ 4'h3
`define ASQ_A_IEN 4'h4
`define ASQ_A_PRI 4'h5
// Results sit at 4'h8 to 4'hF, index in the low three address bits
`define ASQ_RES_SEL 3
`define ASQ_F_RIDX 2:0

// Field positions
`define ASQ_B_SCAN_DONE 0
`define ASQ_B_SEL_DONE 1
`define ASQ_B_SCAN_IE 2
`define ASQ_B_SEL_IE 3
`define ASQ_F_IRQ 3:0
`define ASQ_F_IRQ_HI 7:4
`define ASQ_F_IE 3:2
`define ASQ_F_CH 2:0
`define ASQ_B_RUN 4
`define ASQ_B_TRIG 5
`define ASQ_B_CONT 6
`define ASQ_F_LEN 7:5
`define ASQ_F_PRI 1:0

// Reset values and masks
`define ASQ_IRQ_RST 8'hF0
`define ASQ_IRQ_ONES 4'hF
`define ASQ_SCAN_MASK 8'h77
`define ASQ_SEL_MASK 8'hF7
`define ASQ_CTL_RST 8'h00
`define ASQ_LAST_CH 3'h7
`define ASQ_CH_STEP 3'h1

// Per-channel clock budgets, code 7 in the top slice, code 0 in the bottom
`define ASQ_TOT_TAB {11'h080, 11'h0C0, 11'h100, 11'h180, 11'h200, 11'h300, 11'h400, 11'h600}
`define ASQ_SMP_TAB {11'h04D, 11'h074, 11'h09B, 11'h0E9, 11'h137, 11'h1D3, 11'h26F, 11'h3A7}
`define ASQ_CNV_TAB {11'h01C, 11'h029, 11'h036, 11'h050, 11'h06A, 11'h09E, 11'h0D2, 11'h13A}
`define ASQ_CNT_ONE 11'h001

`endif

// ### logic/asq_phase_timer.sv
// Per-channel clock budget counter with sampling, conversion and other phases
`timescale 1ns/1ps
`default_nettype none
module asq_phase_timer
  import asq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [2:0] code,
  // Status
  output var  asq_phase_t phase,
  output var  logic       done
);
  logic [`ASQ_CW-1:0] cnt_r,  cnt_nxt;
  logic [2:0]         code_r, code_nxt;
  logic               busy_r, busy_nxt;
  logic [`ASQ_CW-1:0] tot, smp, cnv;
  localparam logic [`ASQ_NCH*`ASQ_CW-1:0] TOT_TAB = `ASQ_TOT_TAB;
  localparam logic [`ASQ_NCH*`ASQ_CW-1:0] SMP_TAB = `ASQ_SMP_TAB;
  localparam logic [`ASQ_NCH*`ASQ_CW-1:0] CNV_TAB = `ASQ_CNV_TAB;

  always_comb begin
    tot = TOT_TAB[code_r*`ASQ_CW +: `ASQ_CW];
    smp = SMP_TAB[code_r*`ASQ_CW +: `ASQ_CW];
    cnv = CNV_TAB[code_r*`ASQ_CW +: `ASQ_CW];
    done = busy_r && (cnt_r == tot - `ASQ_CNT_ONE);
    if (!busy_r) begin
      phase = ASQ_PH_IDLE;
    end else if (cnt_r < smp) begin
      phase = ASQ_PH_SMP;
    end else if (cnt_r < smp + cnv) begin
      phase = ASQ_PH_CNV;
    end else begin
      phase = ASQ_PH_OTH;
    end
    cnt_nxt  = cnt_r + `ASQ_CNT_ONE;
    code_nxt = code_r;
    busy_nxt = busy_r && !done;
    if (start) begin
      // Code is latched here, so later writes leave the running budget alone
      cnt_nxt  = '0;
      code_nxt = code;
      busy_nxt = 1'b1;
    end else if (stop || !busy_r) begin
      cnt_nxt  = '0;
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      code_r <= '0;
      busy_r <= 1'b0;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      code_r <= code_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule : asq_phase_timer
`default_nettype wire

// ### logic/asq_pkg.sv
// Types shared by the sequencer and its phase timer
package asq_pkg;
  `include "asq_defs.svh"

  typedef enum logic [1:0] {
    ASQ_ST_IDLE = 2'b00,
    ASQ_ST_SCAN = 2'b01,
    ASQ_ST_SEL  = 2'b10
  } asq_state_t;

  typedef enum logic [1:0] {
    ASQ_PH_IDLE = 2'b00,
    ASQ_PH_SMP  = 2'b01,
    ASQ_PH_CNV  = 2'b10,
    ASQ_PH_OTH  = 2'b11
  } asq_phase_t;

  typedef struct packed {
    logic [`ASQ_AW-1:0] addr;
    logic [`ASQ_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } asq_bus_req_t;

  typedef struct packed {
    logic [2:0] channel;
    asq_phase_t phase;
  } asq_ana_t;
endpackage : asq_pkg

// ### logic/asq_sequencer.sv
// Eight-channel converter scan and select sequencer with register port
//
// How it works
// - Scan-cycle enable bit gates whether scan completion raises a request.
// - Low three bits of scan control give the first scan channel.
// - Trigger bit picks software start or external trigger edge.
// - Continuous bit picks halt or restart from start channel after channel 7.
// - Writing run one starts a scan; writing zero stops it early.
// - Select enable bit gates whether select completion raises a request.
// - Low three bits of select control name the select channel.
// - Length code picks 1536 down to 128 clocks per channel.
// - Scan converts channels upward from start channel through channel 7.
// - A select start abandons the scanned channel and converts at once.
// - After the select, the abandoned channel is reconverted, then scan goes on.
// - Each channel splits into sampling, conversion and other phases.
// - Either completion event sets the single shared request flag when its own enable bit is set.
// - The request reaches the processor only while its enable is set.
// - Two priority bits give the interrupt one of four levels.
// - Scan-cycle flag sets when channel 7 finishes, held until cleared.
// - Select flag sets when a select conversion ends, held until cleared.
// - Each channel keeps its own ten-bit result, upper bits read zero.
// - Length changes during a conversion are ignored.
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer
  import asq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               ce,
  // Register port
  input  wire asq_bus_req_t       bus,
  output var  logic [`ASQ_DW-1:0] rdata,
  // Trigger pin
  input  wire logic               ext_trigger,
  // Converter core
  input  wire logic [`ASQ_RW-1:0] ana_result,
  output var  asq_ana_t           ana,
  // Interrupt controller side
  output var  logic               irq,
  output var  logic [1:0]         irq_prio
);
  logic [7:0]         irq_ctl_r,  irq_ctl_nxt;
  logic [7:0]         scan_ctl_r, scan_ctl_nxt;
  logic [7:0]         sel_ctl_r,  sel_ctl_nxt;
  logic               req_r,      req_nxt;
  logic               ien_r,      ien_nxt;
  logic [1:0]         pri_r,      pri_nxt;
  asq_state_t         st_r,       st_nxt;
  logic               go_r,       go_nxt;
  logic [2:0]         ch_r,       ch_nxt;
  logic [`ASQ_RW-1:0] res_r [`ASQ_NCH];
  logic [`ASQ_RW-1:0] res_nxt [`ASQ_NCH];
  logic [`ASQ_DW-1:0] rdata_nxt;
  asq_ana_t           ana_nxt;
  logic               irq_nxt;
  logic               trg_s1_r, trg_s2_r, trg_s3_r;
  logic               trg_edge;
  logic               wr_irq, wr_scan, wr_sel;
  logic               scan_start_ev, scan_stop_ev;
  logic               sel_start_ev, sel_stop_ev;
  logic               set_scan, set_sel;
  logic               tm_start, tm_stop, tm_done;
  logic               leave_sel;
  asq_phase_t         tm_phase;

  asq_phase_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .start   (tm_start),
    .stop    (tm_stop),
    .code    (sel_ctl_nxt[`ASQ_F_LEN]),
    .phase   (tm_phase),
    .done    (tm_done)
  );

  // Trigger pin comes from outside; the second and third stages feed the edge detect
  assign trg_edge = trg_s2_r && !trg_s3_r;

  always_comb begin
    irq_ctl_nxt  = irq_ctl_r;
    scan_ctl_nxt = scan_ctl_r;
    sel_ctl_nxt  = sel_ctl_r;
    req_nxt      = req_r;
    ien_nxt      = ien_r;
    pri_nxt      = pri_r;
    st_nxt       = st_r;
    go_nxt       = go_r;
    ch_nxt       = ch_r;
    res_nxt      = res_r;
    tm_start     = 1'b0;
    tm_stop      = 1'b0;
    set_scan     = 1'b0;
    set_sel      = 1'b0;
    leave_sel    = 1'b0;
    wr_irq  = bus.wr && (bus.addr == `ASQ_A_IRQ);
    wr_scan = bus.wr && (bus.addr == `ASQ_A_SCAN);
    wr_sel  = bus.wr && (bus.addr == `ASQ_A_SEL);
    scan_start_ev = wr_scan && bus.wdata[`ASQ_B_RUN] && !scan_ctl_r[`ASQ_B_RUN];
    scan_stop_ev  = wr_scan && !bus.wdata[`ASQ_B_RUN];
    sel_start_ev  = wr_sel && bus.wdata[`ASQ_B_RUN] && (st_r != ASQ_ST_SEL);
    sel_stop_ev   = wr_sel && !bus.wdata[`ASQ_B_RUN];

    // Register writes
    if (wr_irq) begin
      irq_ctl_nxt[`ASQ_F_IE] = bus.wdata[`ASQ_F_IE];
      // Software may only clear the flags; hardware alone sets them
      irq_ctl_nxt[`ASQ_B_SCAN_DONE] = irq_ctl_r[`ASQ_B_SCAN_DONE] && bus.wdata[`ASQ_B_SCAN_DONE];
      irq_ctl_nxt[`ASQ_B_SEL_DONE]  = irq_ctl_r[`ASQ_B_SEL_DONE] && bus.wdata[`ASQ_B_SEL_DONE];
    end else if (wr_scan) begin
      scan_ctl_nxt = bus.wdata[7:0] & `ASQ_SCAN_MASK;
    end else if (wr_sel) begin
      sel_ctl_nxt = bus.wdata[7:0] & `ASQ_SEL_MASK;
    end else if (bus.wr && (bus.addr == `ASQ_A_REQ)) begin
      req_nxt = req_r && bus.wdata[0];
    end else if (bus.wr && (bus.addr == `ASQ_A_IEN)) begin
      ien_nxt = bus.wdata[0];
    end else if (bus.wr && (bus.addr == `ASQ_A_PRI)) begin
      pri_nxt = bus.wdata[`ASQ_F_PRI];
    end

    // Scan arming: software start, or trigger edge while run is set
    if (scan_start_ev) begin
      ch_nxt = bus.wdata[`ASQ_F_CH];
      go_nxt = !bus.wdata[`ASQ_B_TRIG];
    end else if (scan_stop_ev) begin
      go_nxt = 1'b0;
    end else if (scan_ctl_r[`ASQ_B_RUN] && scan_ctl_r[`ASQ_B_TRIG] && !go_r && trg_edge) begin
      go_nxt = 1'b1;
      ch_nxt = scan_ctl_r[`ASQ_F_CH];
    end

    // Conversion sequencing
    case (st_r)
      ASQ_ST_SEL: begin
        if (sel_stop_ev) begin
          leave_sel = 1'b1;
        end else if (tm_done) begin
          res_nxt[sel_ctl_r[`ASQ_F_CH]] = ana_result;
          set_sel   = 1'b1;
          sel_ctl_nxt[`ASQ_B_RUN] = 1'b0;
          leave_sel = 1'b1;
        end
      end
      ASQ_ST_SCAN: begin
        if (sel_start_ev) begin
          st_nxt   = ASQ_ST_SEL;
          tm_start = 1'b1;
        end else if (scan_stop_ev) begin
          st_nxt  = ASQ_ST_IDLE;
          tm_stop = 1'b1;
        end else if (tm_done) begin
          res_nxt[ch_r] = ana_result;
          if (ch_r == `ASQ_LAST_CH) begin
            set_scan = 1'b1;
            if (scan_ctl_r[`ASQ_B_CONT]) begin
              ch_nxt   = scan_ctl_r[`ASQ_F_CH];
              tm_start = 1'b1;
            end else begin
              st_nxt  = ASQ_ST_IDLE;
              go_nxt  = 1'b0;
              scan_ctl_nxt[`ASQ_B_RUN] = 1'b0;
            end
          end else begin
            ch_nxt   = ch_r + `ASQ_CH_STEP;
            tm_start = 1'b1;
          end
        end
      end
      default: begin
        if (sel_start_ev) begin
          st_nxt   = ASQ_ST_SEL;
          tm_start = 1'b1;
        end else if (go_nxt) begin
          st_nxt   = ASQ_ST_SCAN;
          tm_start = 1'b1;
        end
      end
    endcase

    // Back to the scan at the channel it left, or to rest
    if (leave_sel) begin
      if (go_nxt) begin
        st_nxt   = ASQ_ST_SCAN;
        tm_start = 1'b1;
      end else begin
        st_nxt  = ASQ_ST_IDLE;
        tm_stop = 1'b1;
      end
    end

    // Hardware set wins over a software clear in the same cycle
    if (set_scan) begin
      irq_ctl_nxt[`ASQ_B_SCAN_DONE] = 1'b1;
    end
    if (set_sel) begin
      irq_ctl_nxt[`ASQ_B_SEL_DONE] = 1'b1;
    end
    if ((set_scan && irq_ctl_r[`ASQ_B_SCAN_IE]) || (set_sel && irq_ctl_r[`ASQ_B_SEL_IE])) begin
      req_nxt = 1'b1;
    end
    irq_nxt = req_nxt && ien_nxt;

    // Channel and phase driven to the converter core
    ana_nxt.channel = (st_nxt == ASQ_ST_SEL) ? sel_ctl_nxt[`ASQ_F_CH] : ch_nxt;
    ana_nxt.phase   = tm_phase;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ctl_r  <= `ASQ_IRQ_RST;
      scan_ctl_r <= `ASQ_CTL_RST;
      sel_ctl_r  <= `ASQ_CTL_RST;
      req_r      <= 1'b0;
      ien_r      <= 1'b0;
      pri_r      <= '0;
      st_r       <= ASQ_ST_IDLE;
      go_r       <= 1'b0;
      ch_r       <= '0;
      ana        <= '0;
      irq        <= 1'b0;
      irq_prio   <= '0;
      trg_s1_r   <= 1'b0;
      trg_s2_r   <= 1'b0;
      trg_s3_r   <= 1'b0;
    end else if (ce) begin
      irq_ctl_r  <= irq_ctl_nxt;
      scan_ctl_r <= scan_ctl_nxt;
      sel_ctl_r  <= sel_ctl_nxt;
      req_r      <= req_nxt;
      ien_r      <= ien_nxt;
      pri_r      <= pri_nxt;
      st_r       <= st_nxt;
      go_r       <= go_nxt;
      ch_r       <= ch_nxt;
      ana        <= ana_nxt;
      irq        <= irq_nxt;
      irq_prio   <= pri_nxt;
      trg_s1_r   <= ext_trigger;
      trg_s2_r   <= trg_s1_r;
      trg_s3_r   <= trg_s2_r;
    end
  end

  // Result store has no reset; contents are undefined until first conversion
  genvar gi;
  generate
    for (gi = 0; gi < `ASQ_NCH; gi++) begin : g_res
      always_ff @(posedge clk_sys) begin
        if (ce) begin
          res_r[gi] <= res_nxt[gi];
        end
      end
    end
  endgenerate

  // Read data appear in the cycle after the read strobe only
  always_comb begin
    rdata_nxt = '0;
    if (bus.rd) begin
      if (bus.addr[`ASQ_RES_SEL]) begin
        rdata_nxt = {{(`ASQ_DW-`ASQ_RW){1'b0}}, res_r[bus.addr[`ASQ_F_RIDX]]};
      end else if (bus.addr == `ASQ_A_IRQ) begin
        rdata_nxt[7:0] = {`ASQ_IRQ_ONES, irq_ctl_r[`ASQ_F_IRQ]};
      end else if (bus.addr == `ASQ_A_SCAN) begin
        rdata_nxt[7:0] = scan_ctl_r;
      end else if (bus.addr == `ASQ_A_SEL) begin
        rdata_nxt[7:0] = sel_ctl_r;
      end else if (bus.addr == `ASQ_A_REQ) begin
        rdata_nxt[0] = req_r;
      end else if (bus.addr == `ASQ_A_IEN) begin
        rdata_nxt[0] = ien_r;
      end else if (bus.addr == `ASQ_A_PRI) begin
        rdata_nxt[`ASQ_F_PRI] = pri_r;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= rdata_nxt;
    end
  end
endmodule : asq_sequencer
`default_nettype wire

// ### verification/asq_core_model.sv
// Behavioural model of the analog multiplexer and converter core
`timescale 1ns/1ps
`default_nettype none
module asq_core_model
  import asq_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Sequencer side
  input  wire asq_ana_t           ana,
  input  wire logic [6:0]         salt,
  output var  logic [`ASQ_RW-1:0] ana_result
);
  logic [`ASQ_RW-1:0] last_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_r <= '0;
    end else begin
      last_r <= ana_result;
    end
  end
  // An idle core flips its output each cycle so a stale value cannot pass as a result
  always_comb begin
    if (ana.phase != ASQ_PH_IDLE) begin
      ana_result = {ana.channel, salt};
    end else begin
      ana_result = ~last_r;
    end
  end
endmodule : asq_core_model
`default_nettype wire

// ### verification/asq_properties.sv
// Port-level concurrent checks for the scan and select sequencer
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"
module asq_properties
  import asq_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               ce,
  // Register port
  input wire asq_bus_req_t       bus,
  input wire logic [`ASQ_DW-1:0] rdata,
  // Pins
  input wire logic               ext_trigger,
  input wire logic [`ASQ_RW-1:0] ana_result,
  input wire asq_ana_t           ana,
  input wire logic               irq,
  input wire logic [1:0]         irq_prio
);
  logic        ien_r;
  logic        ien_nxt;
  asq_ana_t    ana_q_r;
  logic [10:0] run_r;
  logic [10:0] run_nxt;
  // Channel is part of the compare so a preempted sample does not add up
  always_comb begin
    ien_nxt = (ce && bus.wr && bus.addr == `ASQ_A_IEN) ? bus.wdata[0] : ien_r;
    run_nxt = (ana == ana_q_r) ? run_r + 11'h001 : 11'h000;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ien_r   <= 1'b0;
      ana_q_r <= '0;
      run_r   <= 11'h000;
    end else begin
      ien_r   <= ien_nxt;
      ana_q_r <= ana;
      run_r   <= run_nxt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  rd_idle_zero_a: assert property (ce && $past(ce) && !$past(bus.rd) |-> rdata == '0)
    else $error("read data not zero outside read cycle");
  unmapped_read_a: assert property (ce && bus.rd && bus.addr inside {4'h6, 4'h7} |=> rdata == '0)
    else $error("unmapped read not zero");
  irq_hi_ones_a: assert property (ce && bus.rd && bus.addr == `ASQ_A_IRQ |=> rdata[15:4] == 12'h00F)
    else $error("irq control upper bits wrong");
  result_hi_zero_a: assert property (ce && bus.rd && bus.addr[3] |=> rdata[15:10] == 6'h00)
    else $error("result upper bits not zero");
  ctl_fixed_zero_a: assert property (ce && bus.rd && bus.addr inside {4'h1, 4'h2} |=> rdata[15:8] == 8'h00 && !rdata[3])
    else $error("fixed zero control bits set");
  prio_copy_a: assert property (ce && bus.wr && bus.addr == `ASQ_A_PRI ##1 !bus.wr |=> irq_prio == $past(bus.wdata[1:0], 2))
    else $error("priority output does not follow register");
  irq_gate_a: assert property (!ien_r && !$past(ien_r) && !$past(ien_r, 2) |-> !irq)
    else $error("interrupt while enable clear");
  smp_exit_a: assert property (ana.phase != $past(ana.phase) && $past(ana.phase) == ASQ_PH_SMP |-> ana.phase inside {ASQ_PH_CNV, ASQ_PH_IDLE})
    else $error("sampling not followed by conversion");
  start_smp_a: assert property ($past(ana.phase) == ASQ_PH_IDLE && ana.phase != ASQ_PH_IDLE |-> ana.phase == ASQ_PH_SMP)
    else $error("channel not started with sampling");
  smp_len_a: assert property (ana.phase == ASQ_PH_SMP |-> run_nxt < 11'h3A7)
    else $error("sampling phase too long");
  cnv_len_a: assert property (ana.phase == ASQ_PH_CNV |-> run_nxt < 11'h13A)
    else $error("conversion phase too long");
endmodule : asq_properties
bind asq_sequencer asq_properties u_asq_properties (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
  .ext_trigger(ext_trigger), .ana_result(ana_result), .ana(ana), .irq(irq), .irq_prio(irq_prio));
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the scan and select sequencer
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"
module tb;
  import asq_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               ce = 1'b1;
  asq_bus_req_t       bus = '0;
  logic               ext_trigger = 1'b0;
  logic [6:0]         salt = 7'h00;
  logic [`ASQ_DW-1:0] rdata;
  logic [`ASQ_RW-1:0] ana_result;
  asq_ana_t           ana;
  logic               irq;
  logic [1:0]         irq_prio;
  int                 err_count = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  integer             seed = 32'hA121;
  logic [15:0]        d;
  logic [15:0]        v;
  logic [2:0]         s;
  int                 n [4];
  localparam int TOT [8] = '{1536, 1024, 768, 512, 384, 256, 192, 128};
  localparam int SMP [8] = '{935, 623, 467, 311, 233, 155, 116, 77};
  localparam int CNV [8] = '{314, 210, 158, 106, 80, 54, 41, 28};
  always #2.5 clk_sys = ~clk_sys;
  asq_sequencer u_asq_sequencer (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .ext_trigger(ext_trigger), .ana_result(ana_result), .ana(ana), .irq(irq), .irq_prio(irq_prio));
  asq_core_model u_asq_core_model (.clk_sys(clk_sys), .rst(rst), .ana(ana), .salt(salt), .ana_result(ana_result));
  function automatic logic [15:0] res_of(input int ch, input logic [6:0] sv);
    return {6'h00, 3'(ch), sv};
  endfunction : res_of
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] wd);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Idle matches on phase alone, since the channel then carries no meaning
  task automatic wait_ana(input logic [2:0] ch, input asq_phase_t ph, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_sys);
      #1;
      if (ana.phase === ph && (ph == ASQ_PH_IDLE || ana.channel === ch)) break;
    end
    chk(16'(i < lim), 16'h0001);
  endtask : wait_ana
  task automatic meas();
    n = '{0, 0, 0, 0};
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_sys);
      #1;
      n[ana.phase]++;
      if (n[1] > 0 && ana.phase == ASQ_PH_IDLE) break;
    end
  endtask : meas
  task automatic poll(input int b);
    for (int i = 0; i < 600; i++) begin
      rd(`ASQ_A_IRQ);
      if (d[b] === 1'b1) break;
    end
    chk({15'h0000, d[b]}, 16'h0001);
  endtask : poll
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`ASQ_A_IRQ);
    chk(d, 16'h00F0);
    rd(4'h6);
    chk(d, 16'h0000);
    v = 16'($random(seed));
    wr(`ASQ_A_PRI, v);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({14'h0000, irq_prio}, {14'h0000, v[1:0]});
    for (int c = 0; c < 8; c++) begin
      salt <= 7'($random(seed));
      wr(`ASQ_A_IRQ, 16'h0000);
      wr(`ASQ_A_SEL, 16'(c * 33) | 16'h0010);
      fork
        meas();
        begin
          repeat (20) @(posedge clk_sys);
          wr(`ASQ_A_SEL, 16'((7 - c) * 32 + c) | 16'h0010);
        end
      join
      chk(16'(n[1]), 16'(SMP[c]));
      chk(16'(n[2]), 16'(CNV[c]));
      chk(16'(n[3]), 16'(TOT[c] - SMP[c] - CNV[c]));
      poll(1);
      rd(4'h8 + 4'(c));
      chk(d, res_of(c, salt));
    end
    s = 3'($random(seed));
    wr(`ASQ_A_SEL, 16'h00E0);
    wr(`ASQ_A_IEN, 16'h0001);
    wr(`ASQ_A_IRQ, 16'h0004);
    wr(`ASQ_A_SCAN, {13'h0002, s});
    for (int c = int'(s); c < 8; c++) wait_ana(3'(c), ASQ_PH_SMP, 140);
    poll(0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    rd(`ASQ_A_SCAN);
    chk(d, {13'h0000, s});
    for (int c = int'(s); c < 8; c++) begin
      rd(4'h8 + 4'(c));
      chk(d, res_of(c, salt));
    end
    wr(`ASQ_A_REQ, 16'h0000);
    wr(`ASQ_A_IRQ, 16'h0000);
    wr(`ASQ_A_SCAN, 16'h0037);
    repeat (20) @(posedge clk_sys);
    #1;
    chk({14'h0000, ana.phase}, 16'h0000);
    ext_trigger <= 1'b1;
    wait_ana(3'h7, ASQ_PH_SMP, 10);
    ext_trigger <= 1'b0;
    poll(0);
    chk({15'h0000, irq}, 16'h0000);
    wr(`ASQ_A_IRQ, 16'h0000);
    wr(`ASQ_A_SCAN, 16'h0050);
    wait_ana(3'h2, ASQ_PH_SMP, 400);
    wr(`ASQ_A_SEL, 16'h00F4);
    wait_ana(3'h4, ASQ_PH_SMP, 4);
    wait_ana(3'h2, ASQ_PH_SMP, 140);
    rd(`ASQ_A_IRQ);
    chk({15'h0000, d[1]}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wait_ana(3'h3, ASQ_PH_SMP, 140);
    wait_ana(3'h0, ASQ_PH_SMP, 700);
    wr(`ASQ_A_SCAN, 16'h0040);
    wait_ana(3'h0, ASQ_PH_IDLE, 4);
    wr(`ASQ_A_IRQ, 16'h0000);
    rd(4'hB);
    v = d;
    salt <= ~salt;
    wr(`ASQ_A_SEL, 16'h00F3);
    repeat (30) @(posedge clk_sys);
    wr(`ASQ_A_SEL, 16'h00E3);
    wait_ana(3'h0, ASQ_PH_IDLE, 4);
    rd(`ASQ_A_IRQ);
    chk(d, 16'h00F0);
    rd(4'hB);
    chk(d, v);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
